/* rtl/lss_pkg.sv */
// constants, types and timing figures shared by both ends of the linear sensor scan link
// assumes one system clock of 25 MHz; the pixel clock is derived from it by the controller
package lss_pkg;
	localparam int          LSS_SYS_CLK_MHZ     = 25;
	localparam int          LSS_SYS_PERIOD_NS   = 40;
	localparam int          LSS_PIX_MAX_KHZ     = 2000;
	localparam int          LSS_PIX_MIN_NS      = 1000000 / LSS_PIX_MAX_KHZ;
	// least pixel period in system cycles, rounded up
	localparam int          LSS_PIX_DIV_MIN     = (LSS_PIX_MIN_NS + LSS_SYS_PERIOD_NS - 1) / LSS_SYS_PERIOD_NS;
	// even divider keeps the pixel clock inside its duty window
	localparam int          LSS_PIX_DIV         = LSS_PIX_DIV_MIN + (LSS_PIX_DIV_MIN % 2);
	localparam int          LSS_PIXELS          = 512;
	localparam int          LSS_LEAD_TRIGS      = 13;
	localparam int          LSS_FIRST_VALID     = LSS_LEAD_TRIGS + 1;
	localparam int          LSS_SLOTS           = LSS_LEAD_TRIGS + LSS_PIXELS;
	localparam int          LSS_INTEG_EXTRA     = 6;
	localparam int          LSS_MIN_PERIOD      = 18;
	localparam int          LSS_MIN_HIGH        = 2;
	localparam int          LSS_MIN_LOW         = 16;
	localparam int          LSS_FULL_PERIOD     = 528;
	localparam int          LSS_VIDEO_W         = 12;
	localparam int          LSS_FIFO_DEPTH      = 32;
	localparam int          LSS_CNT_W           = 16;
	localparam logic [15:0] LSS_CNT_RST         = 16'h0000;

	typedef enum logic [2:0] {
		LSS_S_IDLE  = 3'b001,
		LSS_S_SHIFT = 3'b010,
		LSS_S_DONE  = 3'b100
	} lss_scan_state_t;
endpackage

/* rtl/lss_if.sv */
// pins between the readout controller and the linear sensor
// assumes both ends share clk_sys_in; the pixel clock here is a sampled level, not a clock
interface lss_if #(
	parameter int VW = 12
);
	logic          pix_clk;
	logic          scan_start_pulse;
	logic          trig;
	logic          scan_done_flag;
	logic [VW-1:0] video;

	modport sensor (input pix_clk, input scan_start_pulse, output trig, output scan_done_flag, output video);
	modport ctrl   (output pix_clk, output scan_start_pulse, input trig, input scan_done_flag, input video);
endinterface

/* rtl/lss_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock; flags are registered so ready and valid come from flip-flops
module lss_fifo #(
	parameter int W     = 12,
	parameter int DEPTH = 32
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	output logic [W-1:0]      out_data_out,
	output logic              out_valid_out,
	input  wire logic         out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0]   count_ff;
	logic [AW:0]   nxt_count;
	logic          push;
	logic          pop;

	assign push         = in_valid_in && in_ready_out;
	assign pop          = out_ready_in && out_valid_out;
	assign out_data_out = mem[rd_ptr_ff];

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = count_ff + 1'b1;
		else if (pop && !push)
			nxt_count = count_ff - 1'b1;
	end

	always_ff @(posedge clk_sys_in) begin
		if (push)
			mem[wr_ptr_ff] <= in_data_in;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_ff     <= '0;
			rd_ptr_ff     <= '0;
			count_ff      <= '0;
			in_ready_out  <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			count_ff      <= nxt_count;
			in_ready_out  <= nxt_count < (AW+1)'(DEPTH);
			out_valid_out <= nxt_count != '0;
		end
	end
endmodule

/* rtl/lss_sensor.sv */
// sensor end: timing generator, shift sequencing, trigger and end-of-scan pins
// assumes pix_clk and scan_start_pulse are synchronous to clk_sys_in; scene pixels arrive by valid/ready
module lss_sensor
	import lss_pkg::*;
#(
	parameter int VW         = LSS_VIDEO_W,
	parameter int FIFO_DEPTH = LSS_FIFO_DEPTH
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_in,
	lss_if.sensor                     link,
	input  wire logic [VW-1:0]        scene_data_in,
	input  wire logic                 scene_valid_in,
	output logic                      scene_ready_out,
	output logic [LSS_CNT_W-1:0]      integ_cycles_out,
	output logic                      scan_active_out,
	output logic                      underrun_out,
	output logic                      start_short_out
);
	localparam logic [9:0]           SLOT_LAST  = 10'(LSS_SLOTS - 1);
	localparam logic [9:0]           SLOT_VALID = 10'(LSS_LEAD_TRIGS);
	localparam logic [LSS_CNT_W-1:0] EXTRA      = LSS_CNT_W'(LSS_INTEG_EXTRA);
	localparam logic [LSS_CNT_W-1:0] MIN_HIGH   = LSS_CNT_W'(LSS_MIN_HIGH);
	localparam logic [LSS_CNT_W-1:0] MIN_LOW    = LSS_CNT_W'(LSS_MIN_LOW);
	localparam logic [LSS_CNT_W-1:0] MIN_PER    = LSS_CNT_W'(LSS_MIN_PERIOD);

	lss_scan_state_t        state_ff;
	lss_scan_state_t        nxt_state;
	logic                   clk_prev_ff;
	logic                   st_prev_ff;
	logic [LSS_CNT_W-1:0]   high_cnt_ff;
	logic [LSS_CNT_W-1:0]   low_cnt_ff;
	logic [LSS_CNT_W-1:0]   per_cnt_ff;
	logic [9:0]             slot_ff;
	logic [9:0]             nxt_slot;
	logic                   trig_ff;
	logic                   done_ff;
	logic [VW-1:0]          video_ff;
	logic                   pix_rise;
	logic                   pix_fall;
	logic                   st_fall;
	logic                   st_rise;
	logic                   advance;
	logic                   present;
	logic [VW-1:0]          fifo_data;
	logic                   fifo_valid;
	logic                   fifo_ready;
	logic                   fifo_pop;

	assign pix_rise = link.pix_clk && !clk_prev_ff;
	assign pix_fall = !link.pix_clk && clk_prev_ff;
	assign st_fall  = pix_rise && !link.scan_start_pulse && st_prev_ff;
	assign st_rise  = pix_rise && link.scan_start_pulse && !st_prev_ff;
	// one slot per pixel clock rising edge, so the data rate is the pixel clock rate
	assign advance  = pix_rise && (state_ff == LSS_S_SHIFT) && (slot_ff != SLOT_LAST);
	assign present  = (st_fall || advance) && (nxt_slot >= SLOT_VALID);
	assign fifo_pop = present;

	assign link.trig           = trig_ff;
	assign link.scan_done_flag = done_ff;
	assign link.video          = video_ff;

	// scene pixels wait here; the sensor drains one per video slot, so the source sees back-pressure
	lss_fifo #(
		.W     (VW),
		.DEPTH (FIFO_DEPTH)
	) u_scene_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_in        (rst_in),
		.in_data_in    (scene_data_in),
		.in_valid_in   (scene_valid_in),
		.in_ready_out  (fifo_ready),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop)
	);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			clk_prev_ff <= 1'b0;
			st_prev_ff  <= 1'b0;
		end else begin
			clk_prev_ff <= link.pix_clk;
			if (pix_rise)
				st_prev_ff <= link.scan_start_pulse;
		end
	end

	// phase lengths counted in pixel clocks; the high count also sizes integration
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			high_cnt_ff <= LSS_CNT_RST;
			low_cnt_ff  <= LSS_CNT_RST;
			per_cnt_ff  <= LSS_CNT_RST;
		end else if (pix_rise) begin
			if (st_rise) begin
				high_cnt_ff <= LSS_CNT_W'(1);
				per_cnt_ff  <= LSS_CNT_W'(1);
			end else begin
				if (link.scan_start_pulse && high_cnt_ff != '1)
					high_cnt_ff <= high_cnt_ff + 1'b1;
				if (per_cnt_ff != '1)
					per_cnt_ff <= per_cnt_ff + 1'b1;
			end
			if (st_fall)
				low_cnt_ff <= LSS_CNT_W'(1);
			else if (!link.scan_start_pulse && low_cnt_ff != '1)
				low_cnt_ff <= low_cnt_ff + 1'b1;
		end
	end

	// sticky: a start pulse that breaks a phase minimum leaves the scan timing undefined
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			start_short_out <= 1'b0;
		else if (st_fall && high_cnt_ff < MIN_HIGH)
			start_short_out <= 1'b1;
		else if (st_rise && (low_cnt_ff < MIN_LOW || per_cnt_ff < MIN_PER))
			start_short_out <= 1'b1;
	end

	// the controller's split of high and low decides this figure
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			integ_cycles_out <= LSS_CNT_RST;
		else if (st_fall)
			integ_cycles_out <= high_cnt_ff + EXTRA;
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_slot  = slot_ff;
		if (st_fall) begin
			nxt_state = LSS_S_SHIFT;
			nxt_slot  = '0;
		end else if (pix_rise) begin
			unique case (state_ff)
				LSS_S_IDLE: begin
					nxt_state = LSS_S_IDLE;
				end
				LSS_S_SHIFT: begin
					if (slot_ff == SLOT_LAST)
						nxt_state = LSS_S_DONE;
					else
						nxt_slot = slot_ff + 1'b1;
				end
				LSS_S_DONE: begin
					nxt_state = LSS_S_IDLE;
				end
				default: begin
					nxt_state = LSS_S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= LSS_S_IDLE;
			slot_ff  <= '0;
		end else begin
			state_ff <= nxt_state;
			slot_ff  <= nxt_slot;
		end
	end

	// trigger rises with each slot and falls with the pixel clock
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			trig_ff <= 1'b0;
		else if (st_fall || advance)
			trig_ff <= 1'b1;
		else if (pix_fall)
			trig_ff <= 1'b0;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			done_ff <= 1'b0;
		else if (st_fall)
			done_ff <= 1'b0;
		else if (pix_rise)
			done_ff <= (nxt_state == LSS_S_DONE);
	end

	// video changes with trigger rise so the controller samples a settled value on it
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			video_ff <= '0;
		else if (present)
			video_ff <= fifo_valid ? fifo_data : '0;
		else if (st_fall || advance)
			video_ff <= '0;
	end

	// an empty fifo at a video slot gives a zero pixel; set wins over the scan-start clear
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			underrun_out <= 1'b0;
		else if (present && !fifo_valid)
			underrun_out <= 1'b1;
		else if (st_fall)
			underrun_out <= 1'b0;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			scan_active_out <= 1'b0;
			scene_ready_out <= 1'b0;
		end else begin
			scan_active_out <= (nxt_state == LSS_S_SHIFT);
			scene_ready_out <= fifo_ready;
		end
	end

	// this ready is one cycle behind the fifo; the fifo's own flag gates the push
	// so a valid met by one stale ready cycle is dropped and never written into the full fifo
endmodule

/* rtl/lss_ctrl.sv */
// readout controller end: pixel clock divider, start pulse generator, video capture
// assumes the sensor end on the same clk_sys_in; captured pixels leave as one-cycle strobes
module lss_ctrl
	import lss_pkg::*;
#(
	parameter int VW        = LSS_VIDEO_W,
	parameter int PIX_DIV   = LSS_PIX_DIV,
	parameter int PERIOD    = LSS_FULL_PERIOD,
	parameter int LOW_CYC   = LSS_MIN_LOW
) (
	input  wire logic           clk_sys_in,
	input  wire logic           rst_in,
	lss_if.ctrl                 link,
	input  wire logic           run_in,
	output logic [VW-1:0]       pix_data_out,
	output logic                pix_valid_out,
	output logic [8:0]          pix_index_out,
	output logic                frame_done_out
);
	localparam int         HALF     = PIX_DIV / 2;
	localparam logic [7:0] DIV_LAST = 8'(PIX_DIV - 1);
	localparam logic [7:0] DIV_HALF = 8'(HALF - 1);
	// high phase takes what the low phase leaves of the period
	localparam logic [9:0] PER_LAST = 10'(PERIOD - 1);
	localparam logic [9:0] HIGH_CYC = 10'(PERIOD - LOW_CYC);
	localparam logic [9:0] FIRST    = 10'(LSS_FIRST_VALID);
	localparam logic [9:0] LAST     = 10'(LSS_SLOTS);

	logic [7:0] div_ff;
	logic       pclk_ff;
	logic [9:0] cyc_ff;
	logic       st_ff;
	logic       trig_prev_ff;
	logic       done_prev_ff;
	logic [9:0] trig_cnt_ff;
	logic [9:0] nxt_trig_cnt;
	logic       trig_rise;
	logic       edge_fall;

	assign link.pix_clk          = pclk_ff;
	assign link.scan_start_pulse = st_ff;
	assign trig_rise             = link.trig && !trig_prev_ff;
	assign edge_fall             = (div_ff == DIV_HALF);
	assign nxt_trig_cnt          = trig_cnt_ff + 1'b1;

	// divider of at least the minimum keeps the pixel rate at or below its maximum
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			div_ff  <= '0;
			pclk_ff <= 1'b0;
		end else begin
			div_ff <= (div_ff == DIV_LAST) ? '0 : div_ff + 1'b1;
			if (div_ff == DIV_LAST)
				pclk_ff <= 1'b1;
			else if (edge_fall)
				pclk_ff <= 1'b0;
		end
	end

	// start changes on the falling pixel edge, half a period clear of the sensor's sampling edge
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cyc_ff <= '0;
			st_ff  <= 1'b0;
		end else if (edge_fall) begin
			if (cyc_ff == '0 && !run_in) begin
				st_ff <= 1'b0;
			end else begin
				cyc_ff <= (cyc_ff == PER_LAST) ? '0 : cyc_ff + 1'b1;
				st_ff  <= cyc_ff < HIGH_CYC;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			trig_prev_ff <= 1'b0;
			done_prev_ff <= 1'b0;
		end else begin
			trig_prev_ff <= link.trig;
			done_prev_ff <= link.scan_done_flag;
		end
	end

	// counting restarts when start drops, before the sensor's first trigger
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			trig_cnt_ff <= '0;
		else if (edge_fall && st_ff && cyc_ff == HIGH_CYC)
			trig_cnt_ff <= '0;
		else if (trig_rise && trig_cnt_ff != '1)
			trig_cnt_ff <= nxt_trig_cnt;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pix_data_out   <= '0;
			pix_valid_out  <= 1'b0;
			pix_index_out  <= '0;
			frame_done_out <= 1'b0;
		end else begin
			pix_valid_out  <= 1'b0;
			frame_done_out <= link.scan_done_flag && !done_prev_ff;
			if (trig_rise && nxt_trig_cnt >= FIRST && nxt_trig_cnt <= LAST) begin
				pix_data_out  <= link.video;
				pix_valid_out <= 1'b1;
				pix_index_out <= 9'(nxt_trig_cnt - FIRST);
			end
		end
	end
endmodule

/* tb/lss_monitor.sv */
// checker of the scan link pins between readout controller and sensor end
// assumes one system clock for both ends and a pixel clock of 7 high and 7 low system cycles
module lss_monitor #(
	parameter int VW      = 12,
	parameter int PIX_DIV = 14,
	parameter int PERIOD  = 528,
	parameter int LOW_CYC = 16
) (
	input wire logic          clk_sys_in,
	input wire logic          rst_in,
	input wire logic          pix_clk,
	input wire logic          scan_start_pulse,
	input wire logic          trig,
	input wire logic          scan_done_flag,
	input wire logic [VW-1:0] video
);
	timeunit 1ns;
	timeprecision 1ns;

	logic st_ff, pclk_ff, trig_ff, seen_ff, armed_ff, launch;
	int   run_ff, trign_ff;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	// first pixel clock rise with start low after a high phase
	assign launch = pix_clk && !pclk_ff && armed_ff && !scan_start_pulse;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff    <= 1'h0;
			pclk_ff  <= 1'h0;
			trig_ff  <= 1'h0;
			seen_ff  <= 1'h0;
			armed_ff <= 1'h0;
			run_ff   <= 0;
			trign_ff <= 0;
		end else begin
			st_ff    <= scan_start_pulse;
			pclk_ff  <= pix_clk;
			trig_ff  <= trig;
			// the low phase before the first high follows reset, so it is not judged
			seen_ff  <= seen_ff || (st_ff && !scan_start_pulse);
			run_ff   <= (scan_start_pulse != st_ff) ? 1 : run_ff + 1;
			armed_ff <= scan_start_pulse || (armed_ff && !(pix_clk && !pclk_ff));
			trign_ff <= launch ? 0 : trign_ff + int'(trig && !trig_ff);
		end
	end

	property p_high_len;
		(st_ff && !scan_start_pulse) |-> run_ff == (PERIOD - LOW_CYC) * PIX_DIV;
	endproperty
	a_high_len: assert property (p_high_len) else $error("start high phase length wrong");

	property p_low_len;
		(!st_ff && scan_start_pulse && seen_ff) |-> run_ff == LOW_CYC * PIX_DIV;
	endproperty
	a_low_len: assert property (p_low_len) else $error("start low phase length wrong");

	// repetition counts are fixed at 7, they follow the default divider of 14 only
	property p_pclk_high;
		$rose(pix_clk) |-> pix_clk [*7] ##1 !pix_clk;
	endproperty
	a_pclk_high: assert property (p_pclk_high) else $error("pixel clock high phase wrong");

	property p_pclk_low;
		$fell(pix_clk) |-> !pix_clk [*7] ##1 pix_clk;
	endproperty
	a_pclk_low: assert property (p_pclk_low) else $error("pixel clock low phase wrong");

	property p_launch;
		launch |=> $rose(trig);
	endproperty
	a_launch: assert property (p_launch) else $error("shifting did not start after start fell");

	property p_trig_cause;
		$rose(trig) |-> $past(pix_clk) && !$past(pix_clk, 2);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger rose without pixel clock rise");

	property p_trig_fall;
		$fell(pix_clk) |=> !trig;
	endproperty
	a_trig_fall: assert property (p_trig_fall) else $error("trigger outlived pixel clock high");

	property p_lead_zero;
		($rose(trig) && trign_ff < 13) |-> video == '0;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("lead slot carried video");

	property p_done_count;
		$rose(scan_done_flag) |-> trign_ff == 525;
	endproperty
	a_done_count: assert property (p_done_count) else $error("done flag after wrong trigger count");

	property p_done_len;
		$rose(scan_done_flag) |-> (scan_done_flag && !trig) [*8] ##6 scan_done_flag ##1 !scan_done_flag;
	endproperty
	a_done_len: assert property (p_done_len) else $error("done flag length wrong");
endmodule

/* tb/linear_sensor_scan_timing_tb_top.sv */
// bench: controller and sensor face each other; a second sensor meets a driver with a too short start pulse
// assumes the package defaults for divider and scan period, system clock 25 MHz
module linear_sensor_scan_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lss_pkg::*;

	logic                   clk_sys_in = 1'h0, rst_in = 1'h1, run = 1'h0, scene_valid = 1'h0;
	logic [LSS_VIDEO_W-1:0] scene_data = '0, pix_data;
	logic                   scene_ready, active, underrun, short_a, short_b, pix_valid, frame_done;
	logic                   feed_on = 1'h0, chk_on = 1'h1, st_q = 1'h0, trig_q = 1'h0;
	logic [LSS_CNT_W-1:0]   integ;
	logic [8:0]             pix_index;
	logic [2:0]             gap = 3'h0;
	int                     err_count = 0, total_checks = 0, sent = 0, rx = 0, trig_cnt = 0;

	lss_if #(.VW(LSS_VIDEO_W)) i_lss_if ();
	lss_if #(.VW(LSS_VIDEO_W)) i_lss_if_bad ();

	lss_sensor i_lss_sensor (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(i_lss_if), .scene_data_in(scene_data),
		.scene_valid_in(scene_valid), .scene_ready_out(scene_ready), .integ_cycles_out(integ),
		.scan_active_out(active), .underrun_out(underrun), .start_short_out(short_a));
	lss_sensor i_lss_sensor_bad (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(i_lss_if_bad), .scene_data_in('0),
		.scene_valid_in(1'h0), .scene_ready_out(), .integ_cycles_out(), .scan_active_out(), .underrun_out(),
		.start_short_out(short_b));
	lss_ctrl i_lss_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(i_lss_if), .run_in(run),
		.pix_data_out(pix_data), .pix_valid_out(pix_valid), .pix_index_out(pix_index), .frame_done_out(frame_done));
	lss_monitor #(.VW(LSS_VIDEO_W), .PIX_DIV(LSS_PIX_DIV), .PERIOD(LSS_FULL_PERIOD), .LOW_CYC(LSS_MIN_LOW))
		i_lss_monitor (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .pix_clk(i_lss_if.pix_clk),
		.scan_start_pulse(i_lss_if.scan_start_pulse), .trig(i_lss_if.trig),
		.scan_done_flag(i_lss_if.scan_done_flag), .video(i_lss_if.video));

	always #20 clk_sys_in = ~clk_sys_in;

	// one word per eight cycles at most, so the late ready copy never lets a word be lost
	always @(posedge clk_sys_in) begin
		gap         <= gap + 3'h1;
		scene_valid <= feed_on && scene_ready && gap == 3'h0;
		if (feed_on && scene_ready && gap == 3'h0) begin
			scene_data  <= sent[LSS_VIDEO_W-1:0];
			sent        <= sent + 1;
		end
	end

	always @(posedge clk_sys_in) begin
		st_q   <= i_lss_if.scan_start_pulse;
		trig_q <= i_lss_if.trig;
		if (st_q && !i_lss_if.scan_start_pulse)
			trig_cnt <= 0;
		else if (i_lss_if.trig && !trig_q)
			trig_cnt <= trig_cnt + 1;
		if (pix_valid) begin
			if (chk_on) begin
				check(32'(pix_index), rx % LSS_PIXELS);
				check(32'(pix_data), rx % (1 << LSS_VIDEO_W));
				check(32'(active), 1);
			end
			rx <= rx + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wait_done();
		int i;
		i = 0;
		do begin
			@(posedge clk_sys_in);
			i++;
		end while (frame_done !== 1'h1 && i < 20000);
		check(32'(i < 20000), 1);
	endtask

	task automatic drive_bad(input int n, input logic st);
		for (int i = 0; i < n; i++) begin
			i_lss_if_bad.scan_start_pulse <= st;
			repeat (7) @(posedge clk_sys_in);
			i_lss_if_bad.pix_clk <= 1'h1;
			repeat (7) @(posedge clk_sys_in);
			i_lss_if_bad.pix_clk <= 1'h0;
		end
	endtask

	task automatic t_short();
		drive_bad(20, 1'h0);
		check(32'(short_b), 0);
		drive_bad(1, 1'h1);
		drive_bad(20, 1'h0);
		check(32'(short_b), 1);
	endtask

	task automatic t_fill();
		feed_on <= 1'h1;
		repeat (600) @(posedge clk_sys_in);
		check(32'(sent), LSS_FIFO_DEPTH);
		check(32'(scene_ready), 0);
		check(32'(i_lss_if.scan_start_pulse), 0);
		check(32'(trig_cnt), 0);
	endtask

	task automatic t_scan();
		run <= 1'h1;
		wait_done();
		check(32'(rx), LSS_PIXELS);
		check(32'(trig_cnt), LSS_SLOTS);
		check(32'(integ), LSS_FULL_PERIOD - LSS_MIN_LOW + LSS_INTEG_EXTRA);
		check(32'(underrun), 0);
		check(32'(short_a), 0);
	endtask

	task automatic t_underrun();
		feed_on <= 1'h0;
		chk_on  <= 1'h0;
		wait_done();
		check(32'(rx), 2 * LSS_PIXELS);
		check(32'(underrun), 1);
	endtask

	initial begin
		i_lss_if_bad.pix_clk          <= 1'h0;
		i_lss_if_bad.scan_start_pulse <= 1'h0;
		repeat (8) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		@(posedge clk_sys_in);
		check(32'(pix_valid), 0);
		check(32'(active), 0);
		t_short();
		t_fill();
		t_scan();
		t_underrun();
		give_verdict();
	end

	initial begin
		repeat (60000) @(posedge clk_sys_in);
		err_count++;
		give_verdict();
	end
endmodule
